/* File: include/exec_regs.svh */
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
// Bus register offsets (byte addresses)
`define OFS_CTRL 4'h0
`define OFS_USER_PTR 4'h4
`define OFS_PSW 4'h8
`define OFS_STAT 4'hc
// Field positions
`define CTRL_USER 0
`define PSW_C 0
`define PSW_Z 1
`define PSW_N 2
`define STAT_BUSY 0
// Opcode fields
`define OP_ORM_HI 4'h9
`define OP_ORM_LO 4'h6
`define AM_PINC 3'h3
`define AM_OFF8 3'h4
`define AM_OFF16 3'h5
`define AM_DIR 3'h6
`define OP_BITOR_B1 8'h08
`define OP_BITOR_B2 3'h3
`define OP_STKD_HI 4'h8
`define OP_STK_LO 3'h7
// Stack pointer register and steps
`define SP_REG 3'h7
`define STEP_W 16'h0002
`define STEP_B 16'h0001
// Execution lengths in clocks
`define CYC_PINC 5'h05
`define CYC_OFF 5'h06
`define CYC_DIR 5'h04
`define CYC_BIT 5'h04
`define CYC_STKD 5'h05
`define CYC_POPL 5'h04
`define CYC_PUSHL 5'h03
`endif

/* File: include/exec_pkg.sv */
package exec_pkg;
    typedef enum logic [3:0] {S_IDLE, S_PTR, S_ADDR, S_MRD, S_OR, S_SRD,
        S_SWR, S_LPOP, S_LWR, S_LPUSH, S_WAIT} state_e;
    typedef enum logic [2:0] {K_ORM, K_BITOR, K_STKD, K_LIST} kind_e;
    typedef struct packed {
        state_e st;
        kind_e kind;
        logic [2:0] mode;
        logic [4:0] cnt;
        logic [4:0] tgt;
        logic [3:0] nitems;
        logic [15:0] ea;
        logic [15:0] sp;
        logic [15:0] imm;
        logic word;
        logic pop;
        logic user;
        logic inv;
        logic grp;
        logic half;
        logic [7:0] list;
        logic [2:0] rsel;
        logic user_mode;
        logic [15:0] user_stack_pointer;
        logic c;
        logic n;
        logic z;
        logic ack;
        logic [31:0] dat;
    } exec_s;
    typedef struct packed {
        logic [7:0][15:0] word;
        logic [15:0] rdata;
    } rf_s;
endpackage

/* File: include/rf_if.sv */
`timescale 1ns/10ps
interface rf_if;
    logic [2:0] raddr;
    logic [15:0] rdata;
    logic [1:0] a_we;
    logic [2:0] a_addr;
    logic [15:0] a_wdata;
    logic b_we;
    logic [2:0] b_addr;
    logic [15:0] b_wdata;
    modport ctrl (output raddr, a_we, a_addr, a_wdata, b_we, b_addr,
        b_wdata, input rdata);
    modport mem (input raddr, a_we, a_addr, a_wdata, b_we, b_addr,
        b_wdata, output rdata);
endinterface

/* File: design/exec_regfile.sv */
`timescale 1ns/10ps
module exec_regfile (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Access port
    rf_if.mem bus
);
    exec_pkg::rf_s r_reg;
    exec_pkg::rf_s r_next;

    // Port A has byte lanes and wins over port B on the same word
    always_comb begin
        r_next = r_reg;
        r_next.rdata = r_reg.word[bus.raddr];
        for (int k = 0; k < 8; k++) begin
            if (bus.b_we && bus.b_addr == k[2:0])
                r_next.word[k] = bus.b_wdata;
            if (bus.a_we[0] && bus.a_addr == k[2:0])
                r_next.word[k][7:0] = bus.a_wdata[7:0];
            if (bus.a_we[1] && bus.a_addr == k[2:0])
                r_next.word[k][15:8] = bus.a_wdata[15:8];
        end
    end

    // State register; read data is registered
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign bus.rdata = r_reg.rdata;
endmodule

/* File: design/list_picker.sv */
`timescale 1ns/10ps
module list_picker (
    // Register list and direction
    input wire logic [7:0] i_list,
    input wire logic i_msb_first,
    // Chosen bit position
    output logic [2:0] o_index
);
    localparam logic [7:0] POS_MASK [3] = '{8'hf0, 8'hcc, 8'haa};
    logic [7:0] rev;
    logic [7:0] low;
    logic [2:0] pos;

    // Mirror the list so one lowest-bit finder serves both directions
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign rev[i] = i_msb_first ? i_list[7 - i] : i_list[i];
            if (i < 3) begin : g_enc
                assign pos[i] = |(low & POS_MASK[2 - i]);
            end
        end
    endgenerate

    assign low = rev & (~rev + 8'h01);
    assign o_index = pos ^ {3{i_msb_first}};
endmodule

/* File: design/or_stack_exec.sv */
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/10ps
`include "exec_regs.svh"
module or_stack_exec (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    // Instruction from the core
    input wire logic I_START,
    input wire logic [47:0] I_INSTR,
    output logic O_BUSY,
    output logic O_DONE,
    // Core access to the register file
    input wire logic I_RF_WE,
    input wire logic [2:0] I_RF_WADDR,
    input wire logic [15:0] I_RF_WDATA,
    input wire logic [2:0] I_RF_RADDR,
    output logic [15:0] O_RF_RDATA,
    // Data memory, read data one cycle after the request
    output logic O_MEM_REQ,
    output logic O_MEM_WE,
    output logic O_MEM_WORD,
    output logic [15:0] O_MEM_ADDR,
    output logic [15:0] O_MEM_WDATA,
    input wire logic [15:0] I_MEM_RDATA,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [3:0] I_WB_ADR,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [3:0] I_WB_SEL,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK
);
    exec_pkg::exec_s r_reg;
    exec_pkg::exec_s r_next;
    rf_if rf ();
    logic [7:0] b1, b2, b3, b4, b5, b6;
    logic dec_orm, dec_bitor, dec_stkd, dec_list, dec_any, take;
    logic [15:0] imm, disp, rdata_sz, or_res, sp_new, step;
    logic [3:0] nbits;
    logic [4:0] list_len;
    logic [2:0] pick, pick_reg;
    logic pick_half, usr_reg, sp_wr, done, wb_hit, wb_wr;

    exec_regfile u_rf (
        .i_clk(I_MCLK),
        .i_rst_b(I_RST_B),
        .bus(rf.mem)
    );

    // Pop takes the lowest bit, push the highest
    list_picker u_pick (
        .i_list(r_reg.list),
        .i_msb_first(!r_reg.pop),
        .o_index(pick)
    );

    // Instruction bytes and decode
    assign {b1, b2, b3, b4, b5, b6} = I_INSTR;
    assign dec_orm = b1[7:4] == `OP_ORM_HI && b2[3:0] == `OP_ORM_LO
        && !b2[7] && (b1[2:0] == `AM_PINC || b1[2:0] == `AM_OFF8
        || b1[2:0] == `AM_OFF16 || b1[2:0] == `AM_DIR);
    assign dec_bitor = b1 == `OP_BITOR_B1 && b2[7:5] == `OP_BITOR_B2
        && b2[3:2] == 2'h0;
    assign dec_stkd = b1[7:4] == `OP_STKD_HI && b1[2:0] == `OP_STK_LO
        && b2[7:6] == 2'h0 && !b2[3];
    assign dec_list = !b1[7] && b1[2:0] == `OP_STK_LO;
    assign dec_any = dec_orm || dec_bitor || dec_stkd || dec_list;
    assign take = r_reg.st == exec_pkg::S_IDLE && I_START && dec_any;

    // Immediate and displacement placement by addressing mode
    always_comb begin
        disp = 16'h0000;
        case (b1[2:0])
            `AM_PINC: imm = b1[3] ? {b3, b4} : {8'h00, b3};
            `AM_OFF8: begin
                disp = {{8{b3[7]}}, b3};
                imm = b1[3] ? {b4, b5} : {8'h00, b4};
            end
            `AM_OFF16: begin
                disp = {b3, b4};
                imm = b1[3] ? {b5, b6} : {8'h00, b5};
            end
            default: imm = b1[3] ? {b4, b5} : {8'h00, b4};
        endcase
    end

    // Count of listed registers sets the list length
    always_comb begin
        nbits = 4'h0;
        for (int k = 0; k < 8; k++)
            nbits = nbits + {3'h0, b2[k]};
        list_len = (b1[5] ? `CYC_POPL : `CYC_PUSHL)
            + ((nbits == 4'h0) ? 5'h00 : {nbits - 4'h1, 1'b0});
    end

    // Byte lists map bit i into the chosen group of byte registers
    assign pick_reg = r_reg.word ? pick : {r_reg.grp, pick[2:1]};
    assign pick_half = !r_reg.word && pick[0];
    // In user mode register 7 already is the user stack pointer
    assign usr_reg = r_reg.user && !r_reg.user_mode;
    assign rdata_sz = r_reg.word ? I_MEM_RDATA : {8'h00, I_MEM_RDATA[7:0]};
    assign or_res = rdata_sz | r_reg.imm;
    assign step = r_reg.word ? `STEP_W : `STEP_B;
    assign wb_hit = I_WB_CYC && I_WB_STB && !r_reg.ack;
    assign wb_wr = wb_hit && I_WB_WE;

    // Sequencer, bus slave and all next-state logic
    always_comb begin
        r_next = r_reg;
        O_MEM_REQ = 1'b0;
        O_MEM_WE = 1'b0;
        O_MEM_WORD = r_reg.word;
        O_MEM_ADDR = r_reg.ea;
        O_MEM_WDATA = 16'h0000;
        rf.raddr = I_RF_RADDR;
        rf.a_we = 2'h0;
        rf.a_addr = I_RF_WADDR;
        rf.a_wdata = I_RF_WDATA;
        rf.b_we = 1'b0;
        rf.b_addr = `SP_REG;
        rf.b_wdata = r_reg.sp;
        sp_new = r_reg.sp;
        sp_wr = 1'b0;
        done = 1'b0;
        // Bus writes go first so hardware updates below win
        r_next.ack = wb_hit;
        if (wb_hit) begin
            r_next.dat = 32'h0000_0000;
            case (I_WB_ADR)
                `OFS_CTRL: begin
                    r_next.dat[`CTRL_USER] = r_reg.user_mode;
                    if (I_WB_WE && I_WB_SEL[0])
                        r_next.user_mode = I_WB_DAT[`CTRL_USER];
                end
                `OFS_USER_PTR: begin
                    r_next.dat[15:0] = r_reg.user_stack_pointer;
                    if (I_WB_WE && I_WB_SEL[0])
                        r_next.user_stack_pointer[7:0] = I_WB_DAT[7:0];
                    if (I_WB_WE && I_WB_SEL[1])
                        r_next.user_stack_pointer[15:8] = I_WB_DAT[15:8];
                end
                `OFS_PSW: begin
                    r_next.dat[`PSW_C] = r_reg.c;
                    r_next.dat[`PSW_Z] = r_reg.z;
                    r_next.dat[`PSW_N] = r_reg.n;
                    if (I_WB_WE && I_WB_SEL[0]) begin
                        r_next.c = I_WB_DAT[`PSW_C];
                        r_next.z = I_WB_DAT[`PSW_Z];
                        r_next.n = I_WB_DAT[`PSW_N];
                    end
                end
                `OFS_STAT: r_next.dat[`STAT_BUSY] = O_BUSY;
                default: r_next.dat = 32'h0000_0000;
            endcase
        end
        if (r_reg.st != exec_pkg::S_IDLE)
            r_next.cnt = r_reg.cnt + 5'h01;
        case (r_reg.st)
            exec_pkg::S_IDLE: begin
                // The core may load registers only while idle
                if (I_RF_WE)
                    rf.a_we = 2'h3;
                if (take) begin
                    r_next.cnt = 5'h00;
                    r_next.word = b1[3];
                    r_next.nitems = nbits;
                    r_next.st = exec_pkg::S_PTR;
                    r_next.rsel = `SP_REG;
                    if (dec_orm) begin
                        r_next.kind = exec_pkg::K_ORM;
                        r_next.mode = b1[2:0];
                        r_next.imm = imm;
                        r_next.rsel = b2[6:4];
                        r_next.ea = disp;
                        if (b1[2:0] == `AM_PINC) begin
                            r_next.tgt = `CYC_PINC;
                        end else if (b1[2:0] == `AM_DIR) begin
                            r_next.tgt = `CYC_DIR;
                            r_next.ea = {5'h00, b2[6:4], b3};
                            r_next.st = exec_pkg::S_MRD;
                        end else begin
                            r_next.tgt = `CYC_OFF;
                        end
                    end else if (dec_bitor) begin
                        r_next.kind = exec_pkg::K_BITOR;
                        r_next.word = 1'b0;
                        r_next.inv = b2[4];
                        r_next.ea = {9'h000, b2[1:0], b3[7:3]};
                        r_next.rsel = b3[2:0];
                        r_next.tgt = `CYC_BIT;
                        r_next.st = exec_pkg::S_MRD;
                    end else if (dec_stkd) begin
                        r_next.kind = exec_pkg::K_STKD;
                        r_next.pop = b2[5];
                        r_next.user = b2[4];
                        r_next.ea = {5'h00, b2[2:0], b3};
                        r_next.tgt = `CYC_STKD;
                    end else begin
                        r_next.kind = exec_pkg::K_LIST;
                        r_next.grp = b1[6];
                        r_next.pop = b1[5];
                        r_next.user = b1[4];
                        r_next.list = b2;
                        r_next.tgt = list_len;
                    end
                end
            end
            exec_pkg::S_PTR: begin
                rf.raddr = r_reg.rsel;
                r_next.st = exec_pkg::S_ADDR;
            end
            exec_pkg::S_ADDR: begin
                if (r_reg.kind == exec_pkg::K_ORM) begin
                    r_next.sp = rf.rdata;
                    r_next.ea = rf.rdata + r_reg.ea;
                    r_next.st = exec_pkg::S_MRD;
                end else begin
                    r_next.sp = usr_reg ? r_reg.user_stack_pointer
                        : rf.rdata;
                    if (r_reg.kind == exec_pkg::K_STKD) begin
                        if (r_reg.pop) begin
                            r_next.st = exec_pkg::S_SRD;
                        end else begin
                            O_MEM_REQ = 1'b1;
                            r_next.st = exec_pkg::S_SWR;
                        end
                    end else if (r_reg.list == 8'h00) begin
                        r_next.st = exec_pkg::S_WAIT;
                    end else if (r_reg.pop) begin
                        r_next.st = exec_pkg::S_LPOP;
                    end else begin
                        // Read of the first item overlaps the setup
                        rf.raddr = pick_reg;
                        r_next.rsel = pick_reg;
                        r_next.half = pick_half;
                        r_next.list = r_reg.list & ~(8'h01 << pick);
                        r_next.st = exec_pkg::S_LPUSH;
                    end
                end
            end
            exec_pkg::S_MRD: begin
                O_MEM_REQ = 1'b1;
                r_next.st = exec_pkg::S_OR;
            end
            exec_pkg::S_OR: begin
                r_next.st = exec_pkg::S_WAIT;
                if (r_reg.kind == exec_pkg::K_ORM) begin
                    O_MEM_REQ = 1'b1;
                    O_MEM_WE = 1'b1;
                    O_MEM_WDATA = or_res;
                    r_next.z = (or_res == 16'h0000);
                    r_next.n = r_reg.word ? or_res[15] : or_res[7];
                    if (r_reg.mode == `AM_PINC) begin
                        rf.b_we = 1'b1;
                        rf.b_addr = r_reg.rsel;
                        rf.b_wdata = r_reg.sp + step;
                    end
                end else begin
                    r_next.c = r_reg.c
                        | (I_MEM_RDATA[r_reg.rsel] ^ r_reg.inv);
                end
            end
            exec_pkg::S_SRD: begin
                O_MEM_REQ = 1'b1;
                O_MEM_ADDR = r_reg.sp;
                r_next.st = exec_pkg::S_SWR;
            end
            exec_pkg::S_SWR: begin
                sp_new = r_reg.pop ? r_reg.sp + `STEP_W
                    : r_reg.sp - `STEP_W;
                sp_wr = 1'b1;
                O_MEM_REQ = 1'b1;
                O_MEM_WE = 1'b1;
                O_MEM_ADDR = r_reg.pop ? r_reg.ea : sp_new;
                O_MEM_WDATA = rdata_sz;
                r_next.st = exec_pkg::S_WAIT;
            end
            exec_pkg::S_LPOP: begin
                O_MEM_REQ = 1'b1;
                O_MEM_ADDR = r_reg.sp;
                r_next.st = exec_pkg::S_LWR;
            end
            exec_pkg::S_LWR: begin
                rf.a_addr = pick_reg;
                rf.a_we = r_reg.word ? 2'h3 : (pick_half ? 2'h2 : 2'h1);
                rf.a_wdata = r_reg.word ? I_MEM_RDATA
                    : {I_MEM_RDATA[7:0], I_MEM_RDATA[7:0]};
                sp_new = r_reg.sp + `STEP_W;
                sp_wr = 1'b1;
                r_next.list = r_reg.list & ~(8'h01 << pick);
                r_next.st = (r_next.list == 8'h00) ? exec_pkg::S_WAIT
                    : exec_pkg::S_LPOP;
            end
            exec_pkg::S_LPUSH: begin
                sp_new = r_reg.sp - `STEP_W;
                sp_wr = 1'b1;
                O_MEM_REQ = 1'b1;
                O_MEM_WE = 1'b1;
                O_MEM_ADDR = sp_new;
                O_MEM_WDATA = r_reg.word ? rf.rdata : {8'h00, r_reg.half
                    ? rf.rdata[15:8] : rf.rdata[7:0]};
                if (r_reg.list != 8'h00) begin
                    rf.raddr = pick_reg;
                    r_next.rsel = pick_reg;
                    r_next.half = pick_half;
                    r_next.list = r_reg.list & ~(8'h01 << pick);
                end else begin
                    r_next.st = exec_pkg::S_WAIT;
                end
            end
            exec_pkg::S_WAIT: r_next.st = exec_pkg::S_WAIT;
            default: r_next.st = exec_pkg::S_IDLE;
        endcase
        // Stack pointer lands in register 7 or the user copy
        if (sp_wr) begin
            r_next.sp = sp_new;
            if (usr_reg) begin
                r_next.user_stack_pointer = sp_new;
            end else begin
                rf.b_we = 1'b1;
                rf.b_wdata = sp_new;
            end
        end
        // Finish exactly on the last clock of the instruction
        if (r_next.st == exec_pkg::S_WAIT
                && r_reg.cnt == r_reg.tgt - 5'h01) begin
            done = 1'b1;
            r_next.st = exec_pkg::S_IDLE;
        end
    end

    // State register
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign O_BUSY = r_reg.st != exec_pkg::S_IDLE;
    assign O_DONE = done;
    assign O_RF_RDATA = rf.rdata;
    assign O_WB_DAT = r_reg.dat;
    assign O_WB_ACK = r_reg.ack;

    // Checks
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);

    chk_pinc_time: assert property (take && dec_orm
        && b1[2:0] == `AM_PINC |=> !O_DONE [*4] ##1 O_DONE)
        else $error("post-increment OR not done in 5 clocks");
    chk_disp_time: assert property (take && dec_orm
        && (b1[2:0] == `AM_OFF8 || b1[2:0] == `AM_OFF16)
        |=> !O_DONE [*5] ##1 O_DONE)
        else $error("displacement OR not done in 6 clocks");
    chk_bit_time: assert property (take && dec_bitor
        |=> !O_DONE [*3] ##1 O_DONE)
        else $error("bit OR not done in 4 clocks");
    chk_stkd_time: assert property (take && dec_stkd
        |=> ##4 O_DONE)
        else $error("direct push or pop not done in 5 clocks");
    chk_or_zero: assert property (r_reg.st == exec_pkg::S_OR
        && r_reg.kind == exec_pkg::K_ORM && !wb_wr
        |=> r_reg.z == ($past(O_MEM_WDATA) == 16'h0000) && $stable(r_reg.c))
        else $error("OR zero flag or carry wrong");
    chk_carry_only: assert property (r_reg.st == exec_pkg::S_OR
        && r_reg.kind == exec_pkg::K_BITOR && !wb_wr
        |=> $stable(r_reg.n) && $stable(r_reg.z)
        && $past(r_reg.c) <= r_reg.c)
        else $error("bit OR touched other flags");
    chk_stack_flags: assert property (O_BUSY && !wb_wr
        && (r_reg.kind == exec_pkg::K_STKD || r_reg.kind == exec_pkg::K_LIST)
        |=> $stable({r_reg.c, r_reg.n, r_reg.z}))
        else $error("stack operation changed a flag");
    chk_push_predec: assert property (r_reg.st == exec_pkg::S_LPUSH
        |=> r_reg.sp == $past(O_MEM_ADDR))
        else $error("push written away from decremented pointer");
    chk_pop_step: assert property (r_reg.st == exec_pkg::S_LWR
        |=> r_reg.sp == $past(r_reg.sp) + `STEP_W)
        else $error("list pop did not add 2");
    // Last restore must land two clocks per listed register after setup
    chk_pop_count: assert property (r_reg.st == exec_pkg::S_LWR
        && r_next.list == 8'h00
        |-> r_reg.cnt == {r_reg.nitems, 1'b0} + 5'h01)
        else $error("list pop read count wrong");
    chk_wb_ack: assert property (wb_hit |=> O_WB_ACK ##1 !O_WB_ACK)
        else $error("bus answer not one cycle");

    cov_pinc: cover property (take && dec_orm && b1[2:0] == `AM_PINC);
    cov_pop_all: cover property (take && dec_list && b1[5] && b2 == 8'hff);
    cov_push_user: cover property (take && dec_list && !b1[5] && b1[4]);
endmodule

/* File: bench/mem_model.sv */
`timescale 1ns/10ps
// Data memory, little-endian words, read data one cycle after the request
module mem_model (
    // Clock
    input wire logic i_clk,
    // Request from the executor
    input wire logic i_req,
    input wire logic i_we,
    input wire logic i_word,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    // Read data
    output logic [15:0] o_rdata = 16'h0
);
    logic [7:0] m [0:1023];
    // Data toggles outside the valid cycle so a late sample never matches
    always @(posedge i_clk) begin
        if (i_req && i_we) begin
            m[i_addr[9:0]] <= i_wdata[7:0];
            if (i_word) m[i_addr[9:0] + 10'h1] <= i_wdata[15:8];
        end
        if (i_req && !i_we) begin
            o_rdata <= {m[i_addr[9:0] + 10'h1], m[i_addr[9:0]]};
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0, rst_b = 1'b0, start = 1'b0, rf_we = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
    logic busy, done, mreq, mwe, mword, ack;
    logic [47:0] instr = 48'h0;
    logic [2:0] rf_wa = 3'h0, rf_ra = 3'h0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [15:0] rf_wd = 16'h0, rdat, mrd, maddr, mwd, v1, v2;
    logic [31:0] wdat = 32'h0, wrd, seed = 32'h2e74c298;
    int fails = 0, num_checks = 0, cnt = 0, cyc_n = 0;
    int dq[$];
    logic [31:0] wq[$];
    // 40 MHz core clock
    initial forever #12.5 clk = ~clk;
    or_stack_exec u_dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_START(start),
        .I_INSTR(instr), .O_BUSY(busy), .O_DONE(done), .I_RF_WE(rf_we),
        .I_RF_WADDR(rf_wa), .I_RF_WDATA(rf_wd), .I_RF_RADDR(rf_ra),
        .O_RF_RDATA(rdat), .O_MEM_REQ(mreq), .O_MEM_WE(mwe),
        .O_MEM_WORD(mword), .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwd),
        .I_MEM_RDATA(mrd), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(wwe),
        .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(wrd),
        .O_WB_ACK(ack));
    mem_model u_mem (.i_clk(clk), .i_req(mreq), .i_we(mwe), .i_word(mword),
        .i_addr(maddr), .i_wdata(mwd), .o_rdata(mrd));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [15:0] mw(input int a);
        return {u_mem.m[a + 1], u_mem.m[a]};
    endfunction
    task automatic pl(input int a, input logic [15:0] d);
        {u_mem.m[a + 1], u_mem.m[a]} = d;
    endtask
    task automatic rfw(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk) rf_we <= 1'b1;
        rf_wa <= a;
        rf_wd <= d;
        @(posedge clk) rf_we <= 1'b0;
    endtask
    task automatic rfr(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk) rf_ra <= a;
        repeat (2) @(posedge clk);
        chk(rdat, e);
    endtask
    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk) cyc <= 1'b1;
        stb <= 1'b1;
        sel <= 4'hf;
        wwe <= w;
        adr <= a;
        wdat <= d;
        // Only the hang guard ends a wait for the answer
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask
    task automatic rdw(input logic [3:0] a, input logic [31:0] e);
        wq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    // Extra edge after done lets the last memory write land
    task automatic run(input logic [47:0] i, input int n);
        dq.push_back(n);
        @(posedge clk) start <= 1'b1;
        instr <= i;
        @(posedge clk) start <= 1'b0;
        do @(posedge clk); while (done !== 1'b1);
        @(posedge clk);
        $display("Test %h finished", i[47:32]);
    endtask
    // Watcher: length from take edge to done, and bus read data
    always @(posedge clk) begin
        if (start && !busy) cnt = 0;
        else cnt++;
        if (done === 1'b1) chk(cnt, dq.pop_front());
        if (ack === 1'b1 && wwe === 1'b0) chk(wrd, wq.pop_front());
    end
    // Hang guard
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        {v1, v2} = $random(seed);
        v2[15] = 1'b1;
        for (int a = 0; a < 16; a += 2) rdw(4'(a), 32'h0);
        u_mem.m[20] = 8'hfd;
        run({8'h08, 8'h60, 8'ha1, 24'h0}, 4);
        rdw(4'h8, 32'h0);
        run({8'h08, 8'h70, 8'ha1, 24'h0}, 4);
        rdw(4'h8, 32'h1);
        rfw(3'h1, 16'h0200);
        pl(512, v1);
        run({8'h9b, 8'h16, v2, 16'h0}, 5);
        chk(mw(512), v1 | v2);
        rfr(3'h1, 16'h0202);
        rdw(4'h8, 32'h5);
        pl(530, v1);
        run({8'h9c, 8'h16, 8'h10, v2, 8'h0}, 6);
        chk(mw(530), v1 | v2);
        pl(546, v2);
        run({8'h9d, 8'h16, 16'h0020, v1}, 6);
        chk(mw(546), v1 | v2);
        pl(320, v1);
        run({8'h9e, 8'h16, 8'h40, v2, 8'h0}, 4);
        chk(mw(320), v1 | v2);
        rfw(3'h7, 16'h0100);
        rfw(3'h2, v2);
        run({8'h0f, 8'h06, 32'h0}, 5);
        chk(mw(254), v2);
        chk(mw(252), 16'h0202);
        rfr(3'h7, 16'h00fc);
        rfw(3'h1, 16'h0);
        rfw(3'h2, 16'h0);
        run({8'h2f, 8'h06, 32'h0}, 6);
        rfr(3'h1, 16'h0202);
        rfr(3'h2, v2);
        rfr(3'h7, 16'h0100);
        wb(1'b1, 4'h4, 32'h0180);
        run({8'h1f, 8'h02, 32'h0}, 3);
        chk(mw(382), 16'h0202);
        rfr(3'h7, 16'h0100);
        run({8'h8f, 8'h30, 8'h30, 24'h0}, 5);
        chk(mw(48), 16'h0202);
        rdw(4'h4, 32'h0180);
        run({8'h87, 8'h00, 8'h30, 24'h0}, 5);
        chk(u_mem.m[254], 32'h02);
        run({8'h67, 8'h02, 32'h0}, 4);
        rfr(3'h4, 16'h0200);
        rfr(3'h7, 16'h0100);
        wb(1'b1, 4'h0, 32'h1);
        rdw(4'h0, 32'h1);
        run({8'h1f, 8'h02, 32'h0}, 3);
        chk(mw(254), 16'h0202);
        rfr(3'h7, 16'h00fe);
        rdw(4'h4, 32'h0180);
        rdw(4'h8, 32'h5);
        stop_test();
    end
endmodule
